// ==== hw/aux_scan_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the
//          auxiliary converter scan and result buffer.
// Assumes: Byte-wide registers on the control port.
// Notes:   Included by the main design file only.
`ifndef AUX_SCAN_REGS_SVH
`define AUX_SCAN_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_RESOLUTION 8'h02
`define OFS_CONV_CFG 8'h03
`define OFS_BUF_CTRL 8'h0D
`define OFS_TRIG_LEVEL 8'h0E
`define OFS_INT_ROUTE 8'h0F
`define OFS_READ_CTRL 8'h12
`define OFS_RESULT_FIRST 8'h36
`define OFS_RESULT_LAST 8'h3B
`define OFS_BUF_WORD_HI 8'hF1
`define OFS_BUF_WORD_LO 8'hF2

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CFG_AUTO_BIT 7
`define BUF_EN_BIT 7
`define BUF_CONT_BIT 6
`define RD_I2C_BIT 7
`define RD_SWSEL_BIT 6
`define RD_SWHOLD_BIT 5

// ---------------------------------------------------------------
// Encodings and reset values
// ---------------------------------------------------------------
`define MODE_BATTERY 4'h6
`define MODE_PORTSCAN 4'h7
`define MODE_AUX1 4'h8
`define MODE_AUX2 4'h9
`define MODE_TEMPERATURE_SINGLE 4'hA
`define MODE_TEMPERATURE_DIFFERENTIAL 4'hB
`define INT_DATA_AVA 2'h1
`define TRIG_LEVEL_RESET 6'h20
`define RING_DEPTH 7'h40

`endif

// ==== hw/aux_scan_pkg.sv ====
// Purpose: Types shared by the auxiliary scan design files.
// Assumes: Nothing.
// Notes:   Constants live in aux_scan_regs.svh.
package aux_scan_pkg;

    // ---------------------------------------------------------------
    // Converter input selector
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_AUX1 = 3'h0,
        SRC_AUX2 = 3'h1,
        SRC_BAT = 3'h2,
        SRC_TEMPERATURE_SINGLE = 3'h3,
        SRC_TEMPERATURE_DIFFERENTIAL = 3'h4
    } src_t;

    // ---------------------------------------------------------------
    // Conversion sequencer states, Gray along the usual path
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11,
        ST_PAUSE = 2'b10
    } seq_t;

endpackage

// ==== hw/stage_fifo.sv ====
// Purpose: Small FIFO between the converter and the result logic.
// Assumes: DEPTH is a power of two.
// Notes:   Read data comes from a register, kept one entry ahead.
`timescale 1ns/1ps
module stage_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    // Whole state of the FIFO
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
        logic [AW-1:0] wr;                // Next slot to fill
        logic [AW-1:0] rd;                // Oldest slot
        logic [AW:0] cnt;                 // Entries held
        logic [WIDTH-1:0] dout;           // Copy of oldest entry
    } fifo_t;

    fifo_t s_reg;
    fifo_t s_next;
    logic push;
    logic pop;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        push = i_in_valid && (s_reg.cnt != (AW+1)'(DEPTH));
        pop = i_out_ready && (s_reg.cnt != '0);
        // Store and advance on a push
        if (push) begin
            s_next.mem[s_reg.wr] = i_in_data;
            s_next.wr = s_reg.wr + AW'(1);
        end
        // Drop the oldest on a pop
        if (pop) begin
            s_next.rd = s_reg.rd + AW'(1);
        end
        // Count follows push and pop
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - (AW+1)'(1);
        end
        // Bypass when the new head is being written now
        if (push && (s_next.rd == s_reg.wr)) begin
            s_next.dout = i_in_data;
        end else begin
            s_next.dout = s_reg.mem[s_next.rd];
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_reg.cnt != '0);
    assign o_out_data = s_reg.dout;

endmodule // stage_fifo

// ==== hw/sar_aux_scan.sv ====
// Purpose: Digital side of the auxiliary converter: input scan,
//          result registers and the 64-entry result ring.
// Assumes: Converter runs on I_REF_CLK and pulses I_CONV_DONE.
// Notes:   Byte register port; reads answer one cycle later.
`timescale 1ns/1ps
`include "aux_scan_regs.svh"

// Behaviour
// - Battery converts at 8, 10, 12 bits
// - Port scan converts three inputs, updates results
// - Buffer enable stores results in 64-ring
// - Read and write pointers, automatic writes
// - Interrupt when write pointer meets trigger
// - Buffer reset sets pointers and trigger
// - Data-available pin at trigger level
// - Buffer conversions only under host control
// - Single-shot waits, restarts on first read
// - Continuous raises interrupt and keeps converting
// - Continuous clears on next write or read
// - Empty read holds; full write overwrites oldest
// - Full and empty flags in word, control
// - Read control bit 7 picks SPI or I2C
// - Bit 6 picks automatic or software hold
// - Software hold bit stops result updates
// - Read word holds full, empty, result
// - Tag bit and fixed set order
module sar_aux_scan (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_REG_WE,
    input wire logic I_REG_RE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_CONV_START,
    output aux_scan_pkg::src_t O_CONV_SRC,
    output logic [1:0] O_CONV_RES,
    input wire logic I_CONV_DONE,
    input wire logic [11:0] I_CONV_DATA,
    output logic O_INTERRUPT_OUT_A,
    output logic O_INTERRUPT_OUT_B
);
    import aux_scan_pkg::*;

    // ---------------------------------------------------------------
    // Whole state of the block
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg;               // Mode, host/auto, int mode
        logic [1:0] res;               // Resolution select
        logic buf_en;                  // Result ring on
        logic buf_cont;                // Continuous ring mode
        logic [5:0] trig_lvl;          // Trigger level, 0 is 64
        logic route;                   // Int on output b
        logic [2:0] rdctl;             // I2C, soft select, hold
        logic [63:0][12:0] mem;        // Ring: tag and result
        logic [5:0] wr_ptr;            // Next slot to write
        logic [5:0] rd_ptr;            // Next slot to read
        logic [5:0] trig_ptr;          // Interrupt slot
        logic [6:0] count;             // Unread entries
        logic [2:0][11:0] results;     // Aux1, aux2, battery
        logic [7:0] word_lo;           // Low byte held for read
        logic word_open;               // High byte read, low due
        logic int_flag;                // Data available
        seq_t state;                   // Sequencer state
        logic [1:0] idx;               // Place within a set
        logic [6:0] set_cnt;           // Conversions this set
        logic conv_start;              // Start pulse
        src_t conv_src;                // Input being converted
        logic [7:0] rdata;             // Read answer
        logic int_a;                   // Output a
        logic int_b;                   // Output b
    } state_t;

    state_t s;
    state_t n;

    logic [3:0] mode;                  // Input select field
    logic hold;                        // Updates stopped
    logic rd_start;                    // High word byte read
    logic pop;                         // Ring entry consumed
    logic ovr;                         // Write over oldest
    logic wr_ring;                     // Ring write now
    logic drain;                       // Entry leaves stage FIFO
    logic last;                        // Last input of a set
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [14:0] fifo_in_data;
    logic fifo_out_valid;
    logic [14:0] fifo_out_data;
    logic [12:0] head;                 // Oldest ring entry
    src_t out_src;                     // Input of drained entry
    logic [1:0] rix;                   // Result register index

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Modes that start conversions
    function automatic logic mode_ok(input logic [3:0] m);
        return (m >= `MODE_BATTERY) && (m <= `MODE_TEMPERATURE_DIFFERENTIAL);
    endfunction

    // Inputs in one set
    function automatic logic [1:0] set_len(input logic [3:0] m);
        return (m == `MODE_PORTSCAN) ? 2'h3 : 2'h1;
    endfunction

    // Input converted at place i of a set
    function automatic src_t src_of(input logic [3:0] m,
                                    input logic [1:0] i);
        case (m)
            `MODE_PORTSCAN: return src_t'({1'b0, i});
            `MODE_BATTERY: return SRC_BAT;
            `MODE_AUX2: return SRC_AUX2;
            `MODE_TEMPERATURE_SINGLE: return SRC_TEMPERATURE_SINGLE;
            `MODE_TEMPERATURE_DIFFERENTIAL: return SRC_TEMPERATURE_DIFFERENTIAL;
            default: return SRC_AUX1;
        endcase
    endfunction

    // Trigger level as a count, zero meaning 64
    function automatic logic [6:0] lvl(input logic [5:0] t);
        return {(t == 6'h00), t};
    endfunction

    // Right-justify the result at the chosen resolution
    function automatic logic [11:0] scale(input logic [11:0] d,
                                          input logic [1:0] r);
        case (r)
            2'h1: return d >> 2;    // 10 bits
            2'h2: return d >> 4;    // 8 bits
            2'h3: return d >> 4;    // 8 bits
            default: return d;      // 12 bits
        endcase
    endfunction

    // Tag: high for aux1 and temperature, low otherwise
    function automatic logic tag_of(input src_t x);
        return (x == SRC_AUX1) || (x == SRC_TEMPERATURE_SINGLE) ||
               (x == SRC_TEMPERATURE_DIFFERENTIAL);
    endfunction

    // ---------------------------------------------------------------
    // Stage FIFO between converter and results
    // ---------------------------------------------------------------
    stage_fifo #(
        .WIDTH(15),
        .DEPTH(16)
    ) u_stage (
        .i_clk(I_REF_CLK),
        .i_resetn(I_RESETN),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(!hold),
        .o_out_data(fifo_out_data)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        n = s;
        n.conv_start = 1'b0;
        mode = s.cfg[5:2];
        last = ((s.idx + 2'h1) == set_len(mode));
        head = s.mem[s.rd_ptr];
        out_src = src_t'(fifo_out_data[14:12]);
        rix = 2'((I_REG_ADDR - `OFS_RESULT_FIRST) >> 1);
        rd_start = I_REG_RE && (I_REG_ADDR == `OFS_BUF_WORD_HI);
        pop = I_REG_RE && (I_REG_ADDR == `OFS_BUF_WORD_LO) &&
              s.word_open && (s.count != 7'h00);
        // Hold source: software bit or read in flight on SPI
        if (s.rdctl[1]) begin
            hold = s.rdctl[0];
        end else begin
            hold = !s.rdctl[2] && s.word_open;
        end
        drain = fifo_out_valid && !hold;
        wr_ring = drain && s.buf_en;
        fifo_in_valid = (s.state == ST_WAIT) && I_CONV_DONE;
        fifo_in_data = {s.conv_src, scale(I_CONV_DATA, s.res)};

        // Conversion sequencer
        case (s.state)
            ST_IDLE: begin
                n.state = ST_IDLE;
            end
            ST_ISSUE: begin
                // Start only with room for the result
                if (fifo_in_ready) begin
                    n.conv_start = 1'b1;
                    n.conv_src = src_of(mode, s.idx);
                    n.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (I_CONV_DONE) begin
                    n.set_cnt = s.set_cnt + 7'h01;
                    n.idx = last ? 2'h0 : s.idx + 2'h1;
                    if (!s.buf_en) begin
                        n.state = last ? ST_IDLE : ST_ISSUE;
                    end else if (!s.buf_cont &&
                                 n.set_cnt == lvl(s.trig_lvl)) begin
                        n.state = ST_PAUSE;
                    end else begin
                        n.state = ST_ISSUE;
                    end
                end
            end
            ST_PAUSE: begin
                // First read of the set restarts conversions
                if (rd_start && s.count != 7'h00) begin
                    n.state = ST_ISSUE;
                    n.set_cnt = 7'h00;
                    n.trig_ptr = s.trig_ptr + s.trig_lvl;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        // Register writes
        if (I_REG_WE) begin
            case (I_REG_ADDR)
                `OFS_CONV_CFG: begin
                    n.cfg = I_REG_WDATA;
                    n.idx = 2'h0;
                    n.set_cnt = 7'h00;
                    n.int_flag = 1'b0;
                    // Host-controlled starts only
                    if (mode_ok(I_REG_WDATA[5:2]) &&
                        !I_REG_WDATA[`CFG_AUTO_BIT]) begin
                        n.state = ST_ISSUE;
                    end else begin
                        n.state = ST_IDLE;
                    end
                end
                `OFS_RESOLUTION: begin
                    n.res = I_REG_WDATA[6:5];
                end
                `OFS_BUF_CTRL: begin
                    n.buf_en = I_REG_WDATA[`BUF_EN_BIT];
                    n.buf_cont = I_REG_WDATA[`BUF_CONT_BIT];
                    // Buffer reset
                    n.rd_ptr = 6'h00;
                    n.wr_ptr = 6'h00;
                    n.trig_ptr = s.trig_lvl;
                    n.count = 7'h00;
                    n.int_flag = 1'b0;
                end
                `OFS_TRIG_LEVEL: begin
                    n.trig_lvl = I_REG_WDATA[5:0];
                end
                `OFS_INT_ROUTE: begin
                    n.route = I_REG_WDATA[0];
                end
                `OFS_READ_CTRL: begin
                    n.rdctl = I_REG_WDATA[7:5];
                end
                default: begin
                    n.route = n.route;
                end
            endcase
        end

        // Register reads
        n.rdata = s.rdata;
        if (I_REG_RE) begin
            case (I_REG_ADDR)
                `OFS_CONV_CFG: n.rdata = s.cfg;
                `OFS_RESOLUTION: n.rdata = {1'b0, s.res, 5'h00};
                `OFS_BUF_CTRL: begin
                    // Ring status in the two low bits
                    n.rdata = {s.buf_en, s.buf_cont, 4'h0,
                               s.count == `RING_DEPTH,
                               s.count == 7'h00};
                end
                `OFS_TRIG_LEVEL: n.rdata = {2'h0, s.trig_lvl};
                `OFS_INT_ROUTE: n.rdata = {7'h00, s.route};
                `OFS_READ_CTRL: n.rdata = {s.rdctl, 5'h00};
                `OFS_BUF_WORD_HI: begin
                    // Flags ride with the word
                    n.rdata = {s.count == `RING_DEPTH,
                               s.count <= 7'h01, 1'b0,
                               head[12:8]};
                    n.word_lo = head[7:0];
                    n.word_open = 1'b1;
                    if (s.buf_en) begin
                        n.int_flag = 1'b0;
                    end
                end
                `OFS_BUF_WORD_LO: begin
                    n.rdata = s.word_lo;
                    n.word_open = 1'b0;
                end
                default: begin
                    n.rdata = 8'h00;
                    // Result register pairs
                    if (I_REG_ADDR >= `OFS_RESULT_FIRST &&
                        I_REG_ADDR <= `OFS_RESULT_LAST) begin
                        if (I_REG_ADDR[0]) begin
                            n.rdata = s.results[rix][7:0];
                        end else begin
                            n.rdata = {4'h0, s.results[rix][11:8]};
                            if (!s.buf_en) begin
                                n.int_flag = 1'b0;
                            end
                        end
                    end
                end
            endcase
        end

        // Result registers outside buffer mode
        if (drain && !s.buf_en && out_src <= SRC_BAT) begin
            n.results[out_src[1:0]] = fifo_out_data[11:0];
            if (out_src == src_of(mode, set_len(mode) - 2'h1)) begin
                n.int_flag = 1'b1;
            end
        end

        // Result ring
        ovr = wr_ring && (n.count == `RING_DEPTH) && !pop;
        if (wr_ring) begin
            n.mem[n.wr_ptr] = {tag_of(out_src),
                               fifo_out_data[11:0]};
            n.wr_ptr = n.wr_ptr + 6'h01;
            if (s.buf_cont) begin
                n.int_flag = 1'b0;
            end
        end
        if (pop || ovr) begin
            n.rd_ptr = n.rd_ptr + 6'h01;
        end
        if (wr_ring && !ovr && !pop) begin
            n.count = n.count + 7'h01;
        end else if (pop && !wr_ring) begin
            n.count = n.count - 7'h01;
        end
        // Trigger: set wins over any clear above
        if (wr_ring && (n.wr_ptr == n.trig_ptr)) begin
            n.int_flag = 1'b1;
            if (s.buf_cont) begin
                n.trig_ptr = n.trig_ptr + s.trig_lvl;
            end
        end

        // Interrupt pins, data-available mode only
        n.int_a = n.int_flag && (n.cfg[1:0] == `INT_DATA_AVA) &&
                  !n.route;
        n.int_b = n.int_flag && (n.cfg[1:0] == `INT_DATA_AVA) &&
                  n.route;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s <= '0;
            s.trig_lvl <= `TRIG_LEVEL_RESET;
            s.trig_ptr <= `TRIG_LEVEL_RESET;
        end else begin
            s <= n;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign O_REG_RDATA = s.rdata;
    assign O_CONV_START = s.conv_start;
    assign O_CONV_SRC = s.conv_src;
    assign O_CONV_RES = s.res;
    assign O_INTERRUPT_OUT_A = s.int_a;
    assign O_INTERRUPT_OUT_B = s.int_b;

endmodule // sar_aux_scan

// ==== tb/conv_model.sv ====
// Purpose: Converter stand-in that answers start pulses
// Assumes: One conversion outstanding at a time
// Notes: Result is {0, source, count} so the bench can predict it
`timescale 1ns/1ps
module conv_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire aux_scan_pkg::src_t i_src,
    output logic o_done,
    output logic [11:0] o_data
);
    import aux_scan_pkg::*;
    int wait_reg; // Cycles left until the answer, 0 when idle
    logic [7:0] cnt_reg; // Conversions finished so far
    src_t src_reg; // Input of the conversion in flight
    // Answer 2 to 5 cycles after each start
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_reg <= 0;
            cnt_reg <= 8'h00;
            src_reg <= SRC_AUX1;
            o_done <= 1'b0;
            o_data <= 12'h000;
        end else begin
            o_done <= 1'b0;
            // Result is not held after its pulse
            if (o_done)
                o_data <= ~o_data;
            if (i_start) begin
                wait_reg <= 2 + int'($urandom % 4);
                src_reg <= i_src;
            end else if (wait_reg > 0) begin
                wait_reg <= wait_reg - 1;
                if (wait_reg == 1) begin
                    o_done <= 1'b1;
                    o_data <= {1'b0, src_reg, cnt_reg};
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
        end
    end
endmodule // conv_model

// ==== tb/sar_aux_scan_asserts.sv ====
// Purpose: Port assertions for the aux scan block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound onto the design at the foot of this file
`timescale 1ns/1ps
module sar_aux_scan_asserts (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_REG_WE,
    input wire logic I_REG_RE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic O_CONV_START,
    input wire aux_scan_pkg::src_t O_CONV_SRC,
    input wire logic O_INTERRUPT_OUT_A,
    input wire logic O_INTERRUPT_OUT_B
);
    import aux_scan_pkg::*;
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESETN);
    logic [2:0] ctl_reg; // Read control bits last written
    // Mirror of the read control bits
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN)
            ctl_reg <= 3'h0;
        else if (I_REG_WE && I_REG_ADDR == 8'h12)
            ctl_reg <= I_REG_WDATA[7:5];
    end
    pins_excl_a: assert property (
        !(O_INTERRUPT_OUT_A && O_INTERRUPT_OUT_B))
        else $error("both interrupt pins high");
    start_pulse_a: assert property (
        O_CONV_START |=> !O_CONV_START) else $error("start too long");
    src_stable_a: assert property (
        !O_CONV_START |-> $stable(O_CONV_SRC)) else $error("source moved");
    rdata_hold_a: assert property (
        !$past(I_REG_RE) |-> $stable(O_REG_RDATA))
        else $error("read data moved");
    unmapped_rd_a: assert property (
        I_REG_RE && I_REG_ADDR == 8'h20 |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    rdctl_rd_a: assert property (
        I_REG_RE && I_REG_ADDR == 8'h12 |=> O_REG_RDATA[7:5] == $past(ctl_reg))
        else $error("read control mismatch");
    int_gate_a: assert property (
        I_REG_WE && I_REG_ADDR == 8'h03 && I_REG_WDATA[1:0] != 2'b01
        |-> ##2 !(O_INTERRUPT_OUT_A || O_INTERRUPT_OUT_B))
        else $error("interrupt pin not gated");
    scan_first_a: assert property (
        I_REG_WE && I_REG_ADDR == 8'h03 &&
        I_REG_WDATA[7:2] inside {6'h07, 6'h08}
        |-> ##[1:4] (O_CONV_START && O_CONV_SRC == SRC_AUX1))
        else $error("first input not started");
    cover property (O_INTERRUPT_OUT_A);
    cover property (O_INTERRUPT_OUT_B);
    cover property (O_CONV_START && O_CONV_SRC == SRC_BAT);
endmodule // sar_aux_scan_asserts
bind sar_aux_scan sar_aux_scan_asserts chk_u (.I_REF_CLK(I_REF_CLK),
    .I_RESETN(I_RESETN), .I_REG_WE(I_REG_WE), .I_REG_RE(I_REG_RE),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA), .O_CONV_START(O_CONV_START),
    .O_CONV_SRC(O_CONV_SRC), .O_INTERRUPT_OUT_A(O_INTERRUPT_OUT_A),
    .O_INTERRUPT_OUT_B(O_INTERRUPT_OUT_B));

// ==== tb/sar_aux_scan_tb.sv ====
// Purpose: Self-checking bench for the aux scan block
// Assumes: Converter stand-in from conv_model
// Notes: Seed 49; random trigger level and control bits
`timescale 1ns/1ps
module sar_aux_scan_tb;
    import aux_scan_pkg::*;
    logic clk, rstn, we, re, st, done, ia, ib;
    logic [7:0] addr, wd, rdat, b, v;
    logic [1:0] res;
    logic [11:0] cd;
    logic [15:0] w;
    src_t src;
    int errors = 0;
    int compares = 0;
    int lvl;
    sar_aux_scan dut_u (.I_REF_CLK(clk), .I_RESETN(rstn), .I_REG_WE(we),
        .I_REG_RE(re), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
        .O_REG_RDATA(rdat), .O_CONV_START(st), .O_CONV_SRC(src),
        .O_CONV_RES(res), .I_CONV_DONE(done), .I_CONV_DATA(cd),
        .O_INTERRUPT_OUT_A(ia), .O_INTERRUPT_OUT_B(ib));
    conv_model conv_u (.i_clk(clk), .i_resetn(rstn), .i_start(st),
        .i_src(src), .o_done(done), .o_data(cd));
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        #1 d = rdat;
    endtask
    // High byte first, the low byte read pops the entry
    task automatic rd_word(output logic [15:0] x);
        rd(8'hF1, x[15:8]);
        rd(8'hF2, x[7:0]);
    endtask
    task automatic wait_int(logic pin_b);
        int n = 0;
        while (n < 2000 && (pin_b ? ib : ia) !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("int_raised", pin_b ? ib : ia, 1'b1);
    endtask
    // Port scan word k: order aux1, aux2, battery; data {0, src, k}
    function automatic logic [15:0] exp_word(int k, logic last);
        logic [2:0] s;
        s = 3'(k % 3);
        return {1'b0, last, 1'b0, s == 3'h0, 1'b0, s, 8'(k)};
    endfunction
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        rstn = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wd = 8'h00;
        lvl = $urandom(49);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h0E, b);
        chk("trig_level", b, 8'h20);
        rd(8'h0D, b);
        chk("buf_status", b[1:0], 2'b01);
        rd(8'h20, b);
        chk("unmapped", b, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'hE0;
            wr(8'h12, v);
            rd(8'h12, b);
            chk("read_ctrl", b[7:5], v[7:5]);
        end
        $display("test registers done");
        lvl = 3 * (1 + $urandom % 2);
        wr(8'h12, 8'h40);
        wr(8'h0E, 8'(lvl));
        wr(8'h0D, 8'h80);
        wr(8'h03, 8'h1D);
        for (int s = 0; s < 2; s++) begin
            wait_int(1'b0);
            wr(8'h12, 8'h60);
            for (int k = 0; k < lvl; k++) begin
                rd_word(w);
                chk("ring_word", w, exp_word(s*lvl+k, k==lvl-1));
            end
            chk("int_cleared", ia, 1'b0);
            rd_word(w);
            chk("empty_read", w[14], 1'b1);
            wr(8'h12, 8'h40);
        end
        wait_int(1'b0);
        wr(8'h03, 8'h00);
        $display("test single shot done");
        wr(8'h0F, 8'h01);
        wr(8'h0E, 8'h02);
        wr(8'h02, 8'h40);
        wr(8'h0D, 8'hC0);
        wr(8'h03, 8'h19);
        wait_int(1'b1);
        chk("pin_a_idle", ia, 1'b0);
        chk("conv_res", res, 2'h2);
        repeat (1500) @(posedge clk);
        wr(8'h12, 8'h60);
        rd(8'h0D, b);
        chk("full_status", b[1:0], 2'b10);
        rd_word(w);
        chk("full_word", {w[15:14], w[12], w[11:4]}, 11'h402);
        wr(8'h03, 8'h00);
        $display("test continuous done");
        wrap_up();
    end
endmodule // sar_aux_scan_tb
